// ---- common/erb_map.svh ----
/*
  Constants for the embedded dual-port RAM block: sizes, lane layout and
  reset values, all as macros.
  Assumes it is included by bare name by the design files.
*/
`ifndef ERB_MAP_SVH
`define ERB_MAP_SVH
`define ERB_DATA_W     36
`define ERB_ADDR_W     12
`define ERB_BE_W       4
`define ERB_WORDS      128
`define ERB_WORD_AW    7
`define ERB_HALF_WORDS 16'h0040
`define ERB_WORD_P     6'h24
`define ERB_WORD_N     6'h20
`define ERB_LANE_P     9
`define ERB_LANE_N     8
`define ERB_DATA_RST   36'h0_0000_0000
`define ERB_ADDR_RST   12'h000
`define ERB_BE_RST     4'h0
`endif

// ---- common/erb_pkg.sv ----
/*
  Types for the embedded dual-port RAM block: clock modes and port widths.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package erb_pkg;
  typedef enum logic [2:0] {
    ERB_TRUE_INDEP,
    ERB_TRUE_IO,
    ERB_SIMPLE_IO,
    ERB_SIMPLE_RW,
    ERB_SINGLE
  } erb_mode_e;

  typedef enum logic [3:0] {
    ERB_W1,
    ERB_W2,
    ERB_W4,
    ERB_W8,
    ERB_W16,
    ERB_W32,
    ERB_W9,
    ERB_W18,
    ERB_W36
  } erb_width_e;
endpackage

// ---- hw/erb_port_in.sv ----
/*
  Input-side register set of one RAM port: address, data, mask, strobes.
  Assumes a one-cycle clock tick that stands for the selected port clock.
*/
`timescale 1ns/100ps
`include "erb_map.svh"
module erb_port_in #(
  parameter int DW = `ERB_DATA_W,
  parameter int AW = `ERB_ADDR_W,
  parameter int BW = `ERB_BE_W
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          tick,
  input  wire logic          ce,
  input  wire logic          clr,
  input  wire logic          re_clr_ok,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] din,
  input  wire logic [BW-1:0] be,
  input  wire logic          we,
  input  wire logic          re,
  output logic      [AW-1:0] addr_q,
  output logic      [DW-1:0] din_q,
  output logic      [BW-1:0] be_q,
  output logic               we_q,
  output logic               re_q,
  output logic               fresh
);
  wire cap       = tick & ce;
  wire arst_n    = rst_n & ~clr;
  // The clear is a level that also cuts in between edges, like the pin.
  wire re_arst_n = rst_n & ~(clr & re_clr_ok);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_q <= `ERB_ADDR_RST;
      din_q  <= `ERB_DATA_RST;
      be_q   <= `ERB_BE_RST;
      we_q   <= 1'b0;
      fresh  <= 1'b0;
    end else begin
      fresh <= cap;
      if (cap) begin
        addr_q <= addr;
        din_q  <= din;
        be_q   <= be;
        we_q   <= we;
      end
    end
  end

  always_ff @(posedge clk or negedge re_arst_n) begin
    if (!re_arst_n) begin
      re_q <= 1'b0;
    end else if (cap) begin
      re_q <= re;
    end
  end
endmodule

// ---- hw/erb_lane_map.sv ----
/*
  Maps one port's address, data and byte mask onto a 36-bit memory word,
  and extracts read data from a word. Purely combinational.
  Assumes the caller holds the memory array and the registers.
*/
`timescale 1ns/100ps
`include "erb_map.svh"
module erb_lane_map #(
  parameter int DW = `ERB_DATA_W,
  parameter int AW = `ERB_ADDR_W,
  parameter int BW = `ERB_BE_W,
  parameter int WA = `ERB_WORD_AW
) (
  input  wire erb_pkg::erb_width_e width,
  input  wire logic                single,
  input  wire logic                half,
  input  wire logic [AW-1:0]       addr,
  input  wire logic [DW-1:0]       din,
  input  wire logic [BW-1:0]       be,
  input  wire logic [DW-1:0]       rword,
  output logic      [WA-1:0]       word,
  output logic      [DW-1:0]       pmask,
  output logic      [DW-1:0]       pdata,
  output logic      [DW-1:0]       rdata,
  output logic                     legal
);
  logic [5:0]    w;
  logic [DW-1:0] lmask;
  logic [DW-1:0] wmask;
  logic [DW-1:0] lm;
  logic [DW-1:0] ld;
  logic [DW-1:0] cl;

  always_comb begin
    unique case (width)
      erb_pkg::ERB_W1:  w = 6'h01;
      erb_pkg::ERB_W2:  w = 6'h02;
      erb_pkg::ERB_W4:  w = 6'h04;
      erb_pkg::ERB_W8:  w = 6'h08;
      erb_pkg::ERB_W16: w = 6'h10;
      erb_pkg::ERB_W32: w = 6'h20;
      erb_pkg::ERB_W9:  w = 6'h09;
      erb_pkg::ERB_W18: w = 6'h12;
      erb_pkg::ERB_W36: w = 6'h24;
      default:          w = 6'h01;
    endcase
  end

  wire par   = (width == erb_pkg::ERB_W9) | (width == erb_pkg::ERB_W18) |
               (width == erb_pkg::ERB_W36);
  wire be_on = (width == erb_pkg::ERB_W16) | (width == erb_pkg::ERB_W18) |
               (width == erb_pkg::ERB_W32) | (width == erb_pkg::ERB_W36);
  wire [5:0]  lw    = par ? `ERB_WORD_P : `ERB_WORD_N;
  wire [15:0] prod  = 16'(addr) * 16'(w);
  wire [15:0] wordi = prod / 16'(lw);
  wire [5:0]  lo    = 6'(prod % 16'(lw));

  // Each single-port memory owns one half of the array.
  assign word  = single ? {half, wordi[WA-2:0]} : wordi[WA-1:0];
  assign legal = ~single | (wordi < `ERB_HALF_WORDS);

  always_comb begin
    lmask = '0;
    wmask = '0;
    for (int i = 0; i < DW; i++) begin
      if (i < int'(w)) begin
        wmask[i] = 1'b1;
        // Lane size is 9 with parity, 8 without.
        lmask[i] = ~be_on |
                   be[par ? i / `ERB_LANE_P : i / `ERB_LANE_N];
      end
    end
  end

  assign lm = lmask << lo;
  assign ld = din << lo;

  always_comb begin
    pmask = '0;
    pdata = '0;
    cl    = '0;
    for (int j = 0; j < DW; j++) begin
      if (par) begin
        pmask[j] = lm[j];
        pdata[j] = ld[j];
        cl[j]    = rword[j];
      end else if ((j % `ERB_LANE_P) != `ERB_LANE_N) begin
        // Byte widths skip the parity bit of each lane.
        pmask[j] = lm[(j / `ERB_LANE_P) * `ERB_LANE_N + j % `ERB_LANE_P];
        pdata[j] = ld[(j / `ERB_LANE_P) * `ERB_LANE_N + j % `ERB_LANE_P];
      end
    end
    for (int i = 0; i < 32; i++) begin
      if (!par) begin
        cl[i] = rword[(i / `ERB_LANE_N) * `ERB_LANE_P + i % `ERB_LANE_N];
      end
    end
  end

  assign rdata = (cl >> lo) & wmask;
endmodule

// ---- hw/erb_ram.sv ----
/*
  Embedded 4,608-bit dual-port RAM block with byte masking, parity lanes
  and the selectable clocking arrangements of both ports.
  Assumes the two block clocks arrive as one-cycle ticks of core_clk and
  that all user inputs are synchronous to core_clk.
*/
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/100ps
`include "erb_map.svh"
module erb_ram #(
  parameter int DW = `ERB_DATA_W,
  parameter int AW = `ERB_ADDR_W,
  parameter int BW = `ERB_BE_W,
  parameter int WA = `ERB_WORD_AW,
  parameter int NW = `ERB_WORDS
) (
  input  wire logic                core_clk,
  input  wire logic                nrst,
  input  wire erb_pkg::erb_mode_e  mode,
  input  wire logic                tick_a,
  input  wire logic                tick_b,
  input  wire erb_pkg::erb_width_e width_a,
  input  wire erb_pkg::erb_width_e width_b,
  input  wire logic                bypass_a,
  input  wire logic                bypass_b,
  input  wire logic                ce_in_a,
  input  wire logic                ce_out_a,
  input  wire logic                ce_in_b,
  input  wire logic                ce_out_b,
  input  wire logic                clr_in_a,
  input  wire logic                clr_out_a,
  input  wire logic                clr_in_b,
  input  wire logic                clr_out_b,
  input  wire logic [AW-1:0]       addr_a,
  input  wire logic [DW-1:0]       din_a,
  input  wire logic [BW-1:0]       be_a,
  input  wire logic                we_a,
  input  wire logic                re_a,
  input  wire logic [AW-1:0]       addr_b,
  input  wire logic [DW-1:0]       din_b,
  input  wire logic [BW-1:0]       be_b,
  input  wire logic                we_b,
  input  wire logic                re_b,
  output logic      [DW-1:0]       q_a,
  output logic      [DW-1:0]       q_b,
  output logic                     cfg_err
);
  logic          rst_meta;
  logic          rst_n;
  logic [DW-1:0] mem [NW];

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  wire is_true   = (mode == erb_pkg::ERB_TRUE_INDEP) |
                   (mode == erb_pkg::ERB_TRUE_IO);
  wire is_simple = (mode == erb_pkg::ERB_SIMPLE_IO) |
                   (mode == erb_pkg::ERB_SIMPLE_RW);
  wire is_io     = (mode == erb_pkg::ERB_TRUE_IO) |
                   (mode == erb_pkg::ERB_SIMPLE_IO);
  wire single    = (mode == erb_pkg::ERB_SINGLE);

  wire wide_a = (width_a == erb_pkg::ERB_W32) | (width_a == erb_pkg::ERB_W36);
  wire wide_b = (width_b == erb_pkg::ERB_W32) | (width_b == erb_pkg::ERB_W36);
  assign cfg_err = is_true & (wide_a | wide_b);

  // Clock routing: port A inputs always on clock A and port B outputs on
  // clock B; in/out mode moves B inputs to A and A outputs to B.
  wire tk_in_a  = tick_a;
  wire tk_in_b  = is_io ? tick_a : tick_b;
  wire tk_out_a = is_io ? tick_b : tick_a;
  wire tk_out_b = tick_b;

  // Simple dual-port: port A only writes, port B only reads.
  wire we_a_ok = we_a;
  wire re_a_ok = re_a & ~is_simple;
  wire we_b_ok = we_b & ~is_simple;
  wire re_b_ok = re_b;

  logic [AW-1:0] aq_a;
  logic [AW-1:0] aq_b;
  logic [DW-1:0] dq_a;
  logic [DW-1:0] dq_b;
  logic [BW-1:0] bq_a;
  logic [BW-1:0] bq_b;
  logic          wq_a;
  logic          wq_b;
  logic          rq_a;
  logic          rq_b;
  logic          fr_a;
  logic          fr_b;

  erb_port_in #(.DW(DW), .AW(AW), .BW(BW)) u_in_a (
    .clk       (core_clk),
    .rst_n     (rst_n),
    .tick      (tk_in_a),
    .ce        (ce_in_a),
    .clr       (clr_in_a),
    .re_clr_ok (~is_simple),
    .addr      (addr_a),
    .din       (din_a),
    .be        (be_a),
    .we        (we_a_ok),
    .re        (re_a_ok),
    .addr_q    (aq_a),
    .din_q     (dq_a),
    .be_q      (bq_a),
    .we_q      (wq_a),
    .re_q      (rq_a),
    .fresh     (fr_a)
  );

  erb_port_in #(.DW(DW), .AW(AW), .BW(BW)) u_in_b (
    .clk       (core_clk),
    .rst_n     (rst_n),
    .tick      (tk_in_b),
    .ce        (ce_in_b),
    .clr       (clr_in_b),
    .re_clr_ok (~is_simple),
    .addr      (addr_b),
    .din       (din_b),
    .be        (be_b),
    .we        (we_b_ok),
    .re        (re_b_ok),
    .addr_q    (aq_b),
    .din_q     (dq_b),
    .be_q      (bq_b),
    .we_q      (wq_b),
    .re_q      (rq_b),
    .fresh     (fr_b)
  );

  logic [WA-1:0] word_a;
  logic [WA-1:0] word_b;
  logic [DW-1:0] pm_a;
  logic [DW-1:0] pm_b;
  logic [DW-1:0] pd_a;
  logic [DW-1:0] pd_b;
  logic [DW-1:0] rd_a;
  logic [DW-1:0] rd_b;
  logic          ok_a;
  logic          ok_b;

  erb_lane_map #(.DW(DW), .AW(AW), .BW(BW), .WA(WA)) u_map_a (
    .width  (width_a),
    .single (single),
    .half   (1'b0),
    .addr   (aq_a),
    .din    (dq_a),
    .be     (bq_a),
    .rword  (mem[word_a]),
    .word   (word_a),
    .pmask  (pm_a),
    .pdata  (pd_a),
    .rdata  (rd_a),
    .legal  (ok_a)
  );

  erb_lane_map #(.DW(DW), .AW(AW), .BW(BW), .WA(WA)) u_map_b (
    .width  (width_b),
    .single (single),
    .half   (1'b1),
    .addr   (aq_b),
    .din    (dq_b),
    .be     (bq_b),
    .rword  (mem[word_b]),
    .word   (word_b),
    .pmask  (pm_b),
    .pdata  (pd_b),
    .rdata  (rd_b),
    .legal  (ok_b)
  );

  // One internal write pulse per loaded input register set.
  wire wr_a = fr_a & wq_a & ok_a & ~cfg_err;
  wire wr_b = fr_b & wq_b & ok_b & ~cfg_err;
  wire rd_go_a = fr_a & rq_a & ok_a;
  wire rd_go_b = fr_b & rq_b & ok_b;

  // Unmasked lanes keep old bits; an all-zero mask rewrites the old word.
  wire [DW-1:0] new_a  = (mem[word_a] & ~pm_a) | (pd_a & pm_a);
  // Same-word writes merge so port A lanes are not lost to port B.
  wire [DW-1:0] base_b = (wr_a && word_a == word_b) ? new_a : mem[word_b];
  wire [DW-1:0] new_b  = (base_b & ~pm_b) | (pd_b & pm_b);

  always_ff @(posedge core_clk) begin
    if (wr_a) begin
      mem[word_a] <= new_a;
    end
    if (wr_b) begin
      mem[word_b] <= new_b;
    end
  end

  logic [DW-1:0] hold_a;
  logic [DW-1:0] hold_b;
  logic [DW-1:0] oreg_a;
  logic [DW-1:0] oreg_b;
  wire oarst_a_n = rst_n & ~clr_out_a;
  wire oarst_b_n = rst_n & ~clr_out_b;

  always_ff @(posedge core_clk or negedge oarst_a_n) begin
    if (!oarst_a_n) begin
      hold_a <= `ERB_DATA_RST;
      oreg_a <= `ERB_DATA_RST;
    end else begin
      if (rd_go_a) begin
        hold_a <= rd_a;
      end
      if (tk_out_a && ce_out_a) begin
        oreg_a <= hold_a;
      end
    end
  end

  always_ff @(posedge core_clk or negedge oarst_b_n) begin
    if (!oarst_b_n) begin
      hold_b <= `ERB_DATA_RST;
      oreg_b <= `ERB_DATA_RST;
    end else begin
      if (rd_go_b) begin
        hold_b <= rd_b;
      end
      if (tk_out_b && ce_out_b) begin
        oreg_b <= hold_b;
      end
    end
  end

  assign q_a = bypass_a ? hold_a : oreg_a;
  assign q_b = bypass_b ? hold_b : oreg_b;
endmodule

// ---- bench/erb_ram_props.sv ----
/*
  Concurrent checks on the ports of the embedded dual-port RAM block.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/100ps
module erb_ram_props #(
  parameter int DW = 36
) (
  input wire logic                core_clk,
  input wire logic                nrst,
  input wire erb_pkg::erb_mode_e  mode,
  input wire logic                tick_a,
  input wire logic                tick_b,
  input wire erb_pkg::erb_width_e width_a,
  input wire erb_pkg::erb_width_e width_b,
  input wire logic                bypass_a,
  input wire logic                bypass_b,
  input wire logic                ce_in_a,
  input wire logic                ce_in_b,
  input wire logic                ce_out_a,
  input wire logic                ce_out_b,
  input wire logic                clr_out_a,
  input wire logic                clr_out_b,
  input wire logic                re_a,
  input wire logic                re_b,
  input wire logic [DW-1:0]       q_a,
  input wire logic [DW-1:0]       q_b,
  input wire logic                cfg_err
);
  wire tdp = mode inside {erb_pkg::ERB_TRUE_INDEP, erb_pkg::ERB_TRUE_IO};
  wire wa  = width_a inside {erb_pkg::ERB_W32, erb_pkg::ERB_W36};
  wire wb  = width_b inside {erb_pkg::ERB_W32, erb_pkg::ERB_W36};
  wire rd_a  = tick_a && ce_in_a && re_a;
  wire rd_b  = tick_b && ce_in_b && re_b;
  wire ot_a  = tick_a && ce_out_a;
  wire ot_b  = tick_b && ce_out_b;
  wire oio_a = tick_b && ce_out_a;
  wire ind   = mode == erb_pkg::ERB_TRUE_INDEP;
  wire srw   = mode == erb_pkg::ERB_SIMPLE_RW;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  a_cfg_err_map: assert property (cfg_err == (tdp && (wa || wb)))
    else $error("cfg_err disagrees with mode and widths");
  a_clr_q_a: assert property (clr_out_a |-> q_a == '0)
    else $error("q_a not cleared");
  a_clr_q_b: assert property (clr_out_b |-> q_b == '0)
    else $error("q_b not cleared");
  a_indep_q_a: assert property (ind && $stable(mode)
    && $stable(bypass_a) && !clr_out_a && !$past(clr_out_a) && $changed(q_a)
    |-> (bypass_a ? $past(rd_a, 2) : $past(ot_a)))
    else $error("q_a moved without a port A read");
  a_indep_q_b: assert property (ind && $stable(mode)
    && $stable(bypass_b) && !clr_out_b && !$past(clr_out_b) && $changed(q_b)
    |-> (bypass_b ? $past(rd_b, 2) : $past(ot_b)))
    else $error("q_b moved without a port B read");
  a_io_out_a: assert property (mode == erb_pkg::ERB_TRUE_IO
    && $stable(mode) && !bypass_a && !$past(bypass_a) && !clr_out_a
    && !$past(clr_out_a) && $changed(q_a) |-> $past(oio_a))
    else $error("q_a loaded without the output clock");
  a_simple_q_a: assert property (srw
    && $past(mode, 4) == erb_pkg::ERB_SIMPLE_RW && !clr_out_a |-> $stable(q_a))
    else $error("q_a moved in simple dual-port mode");
  a_srw_q_b: assert property (srw && $stable(mode)
    && $stable(bypass_b) && !clr_out_b && !$past(clr_out_b)
    |-> !$changed(q_b) || (bypass_b ? $past(rd_b, 2) : $past(ot_b)))
    else $error("q_b moved without a read clock event");
endmodule

// ---- bench/erb_user_model.sv ----
/*
  User logic beside the RAM: makes the two block clock ticks.
  Assumes core_clk; tick B runs at half rate when slow is high.
*/
`timescale 1ns/100ps
module erb_user_model (
  input  wire logic core_clk,
  input  wire logic nrst,
  input  wire logic run,
  input  wire logic slow,
  output logic      tick_a,
  output logic      tick_b
);
  logic ph_reg;
  // A slower clock B exposes any port wired to the wrong clock.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ph_reg <= 1'b0;
      tick_a <= 1'b0;
      tick_b <= 1'b0;
    end else begin
      ph_reg <= ~ph_reg;
      tick_a <= run;
      tick_b <= run & (~slow | ph_reg);
    end
  end
endmodule

// ---- bench/test_embedded_dual_port_ram_block.sv ----
/*
  Self-checking bench for the embedded dual-port RAM block.
  Assumes the design, package and user model are compiled first.
*/
`timescale 1ns/100ps
module test_embedded_dual_port_ram_block;
  logic core_clk, nrst, run, slow, tick_a, tick_b, cfg_err;
  erb_pkg::erb_mode_e  mode;
  erb_pkg::erb_width_e width_a, width_b;
  logic bypass_a, bypass_b, ce_in_a, ce_out_a, ce_in_b, ce_out_b;
  logic clr_in_a, clr_out_a, clr_in_b, clr_out_b, we_a, re_a, we_b, re_b;
  logic [11:0] addr_a, addr_b, ad;
  logic [35:0] din_a, din_b, q_a, q_b, ex, d;
  logic [3:0]  be_a, be_b, mk;
  logic [31:0] r;
  int seed = 66926;
  int fail_count = 0;
  int checks = 0;
  int wv[9] = '{1, 2, 4, 8, 9, 16, 18, 32, 36};
  erb_pkg::erb_width_e wt[9] = '{erb_pkg::ERB_W1, erb_pkg::ERB_W2,
    erb_pkg::ERB_W4, erb_pkg::ERB_W8, erb_pkg::ERB_W9, erb_pkg::ERB_W16,
    erb_pkg::ERB_W18, erb_pkg::ERB_W32, erb_pkg::ERB_W36};
  erb_user_model u_user (.core_clk(core_clk), .nrst(nrst), .run(run),
    .slow(slow), .tick_a(tick_a), .tick_b(tick_b));
  erb_ram u_dut (.*);
  // Lanes are 9 bits at parity widths; below 16 bits the mask is ignored.
  function automatic logic [35:0] merge(logic [35:0] o, n, logic [3:0] m,
                                        int w);
    int l;
    logic [35:0] x;
    l = (w % 9 == 0) ? 9 : 8;
    x = o;
    for (int i = 0; i < w; i++)
      if (m[i/l] || w < 16) x[i] = n[i];
    return x;
  endfunction
  task automatic final_report;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(logic [35:0] got, exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Holds the request until the edge where the port's input tick is seen.
  task automatic acc(bit p, logic w, rr, logic [11:0] a, logic [35:0] v,
                     logic [3:0] m, logic c);
    int n;
    @(posedge core_clk);
    if (!p) begin
      {we_a, re_a, addr_a, din_a, be_a, ce_in_a} <= {w, rr, a, v, m, c};
    end else begin
      {we_b, re_b, addr_b, din_b, be_b, ce_in_b} <= {w, rr, a, v, m, c};
    end
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (!((p && !(mode inside {erb_pkg::ERB_TRUE_IO,
      erb_pkg::ERB_SIMPLE_IO})) ? tick_b : tick_a) && n < 20);
    if (n >= 20) begin
      fail_count++;
      final_report;
    end
    {we_a, re_a, we_b, re_b} <= 4'h0;
    {ce_in_a, ce_in_b} <= 2'h3;
  endtask
  task automatic rd(bit p, logic [11:0] a, logic [35:0] e);
    acc(p, 0, 1, a, '0, '0, 1);
    repeat (6) @(posedge core_clk);
    check(p ? q_b : q_a, e);
  endtask
  initial begin
    core_clk = 0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    {nrst, run, slow, bypass_a, bypass_b, we_a, re_a, we_b, re_b} = '0;
    {clr_in_a, clr_out_a, clr_in_b, clr_out_b} = '0;
    {ce_in_a, ce_out_a, ce_in_b, ce_out_b} = '1;
    {addr_a, addr_b, din_a, din_b, be_a, be_b} = '0;
    mode = erb_pkg::ERB_SIMPLE_RW;
    width_a = erb_pkg::ERB_W36;
    width_b = erb_pkg::ERB_W36;
    repeat (20) @(posedge core_clk);
    nrst <= 1;
    repeat (4) @(posedge core_clk);
    run <= 1;
    slow <= 1;
    for (int k = 0; k < 9; k++) begin
      r = $random(seed);
      ad = 12'(r[6:0]);
      ex = '0;
      width_a <= wt[k];
      width_b <= wt[k];
      for (int m = -1; m < 16; m++) begin
        d = 36'({$random(seed), $random(seed)});
        r = $random(seed);
        mk = (m < 0) ? 4'hF : 4'(m);
        acc(0, 1, 0, ad, d, mk, r[0] | r[1] | (m < 0));
        if (r[0] | r[1] | (m < 0)) ex = merge(ex, d, mk, wv[k]);
        bypass_b <= r[2];
        rd(1, ad, ex);
      end
    end
    mode <= erb_pkg::ERB_TRUE_INDEP;
    acc(0, 1, 0, ad, ~ex, 4'hF, 1);
    check(36'(cfg_err), 36'h1);
    repeat (2) @(posedge core_clk);
    mode <= erb_pkg::ERB_SIMPLE_RW;
    rd(1, ad, ex);
    mode <= erb_pkg::ERB_TRUE_INDEP;
    width_a <= erb_pkg::ERB_W16;
    width_b <= erb_pkg::ERB_W16;
    d = 36'({$random(seed), $random(seed)});
    acc(0, 1, 0, ad, d, 4'hF, 1);
    acc(1, 1, 0, ad ^ 12'h1, ~d, 4'h3, 1);
    r = $random(seed);
    bypass_a <= r[0];
    rd(1, ad, {20'h0, d[15:0]});
    rd(0, ad ^ 12'h1, {20'h0, ~d[15:0]});
    // A clear right at the capture edge must cancel the pending write.
    acc(0, 1, 0, ad, ~d, 4'hF, 1);
    clr_in_a <= 1;
    @(posedge core_clk);
    clr_in_a <= 0;
    rd(1, ad, {20'h0, d[15:0]});
    mode <= erb_pkg::ERB_TRUE_IO;
    bypass_a <= 0;
    acc(0, 1, 0, ad, ~d, 4'h2, 1);
    // With its enable low the output register keeps the previous read.
    ce_out_a <= 0;
    rd(0, ad, {20'h0, ~d[15:0]});
    ce_out_a <= 1;
    repeat (4) @(posedge core_clk);
    check(q_a, {20'h0, ~d[15:8], d[7:0]});
    {clr_out_a, clr_out_b} <= 2'h3;
    @(posedge core_clk);
    {clr_out_a, clr_out_b} <= 2'h0;
    @(posedge core_clk);
    check(q_a, '0);
    check(q_b, '0);
    mode <= erb_pkg::ERB_SINGLE;
    width_a <= erb_pkg::ERB_W36;
    width_b <= erb_pkg::ERB_W36;
    ad = ad & 12'h03F;
    acc(0, 1, 0, ad, d, 4'hF, 1);
    acc(1, 1, 0, ad, ~d, 4'hF, 1);
    rd(0, ad, d);
    rd(1, ad, ~d);
    // Simple in/out mode: port B writes are refused, B inputs use clock A.
    mode <= erb_pkg::ERB_SIMPLE_IO;
    acc(1, 1, 0, ad, ~d, 4'hF, 1);
    rd(1, ad, d);
    acc(0, 1, 0, ad, ~d, 4'h5, 1);
    rd(1, ad, {d[35:27], ~d[26:18], d[17:9], ~d[8:0]});
    final_report;
  end
endmodule
bind erb_ram erb_ram_props #(.DW(DW)) u_props (.*);
